// *** verilog/serial_flash_pkg.sv ***
// Shared constants, opcodes and helpers for the serial flash front end.
`default_nettype none
package serial_flash_pkg;

  // Recognised opcodes.
  localparam logic [7:0] OP_WR_ENABLE   = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE  = 8'h04;
  localparam logic [7:0] OP_WR_EN_VOL   = 8'h50;
  localparam logic [7:0] OP_RD_STATUS   = 8'h05;
  localparam logic [7:0] OP_WR_STATUS   = 8'h01;
  localparam logic [7:0] OP_READ        = 8'h03;
  localparam logic [7:0] OP_FAST_READ   = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT    = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO     = 8'hBB;
  localparam logic [7:0] OP_PAGE_ERASE  = 8'h81;
  localparam logic [7:0] OP_SECT_ERASE  = 8'h20;
  localparam logic [7:0] OP_HALF_ERASE  = 8'h52;
  localparam logic [7:0] OP_BLK_ERASE   = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE0 = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE1 = 8'hC7;
  localparam logic [7:0] OP_PROGRAM     = 8'h02;
  localparam logic [7:0] OP_POWER_DOWN  = 8'hB9;
  localparam logic [7:0] OP_WAKE_SIG    = 8'hAB;
  localparam logic [7:0] OP_MFR_ID      = 8'h90;
  localparam logic [7:0] OP_DUAL_ID     = 8'h92;
  localparam logic [7:0] OP_JEDEC_ID    = 8'h9F;
  localparam logic [7:0] OP_RST_ENABLE  = 8'h66;
  localparam logic [7:0] OP_RST         = 8'h99;
  localparam logic [7:0] OP_UNIQUE_ID   = 8'h4B;

  // Array organisation.
  localparam int            PAGE_BYTES   = 256;
  localparam int            SECTOR_PAGES = 16;
  localparam int            SECTOR_COUNT = 64;
  localparam logic [23:0]   ADDR_BOTTOM  = 24'h00_0000;
  localparam logic [23:0]   ADDR_TOP     = 24'h03_FFFF;

  // Byte positions within a frame, and the idle output byte.
  localparam logic [2:0]    IDX_ADDR_FIRST = 3'h1;
  localparam logic [2:0]    IDX_ADDR_LAST  = 3'h3;
  localparam logic [2:0]    IDX_MODE       = 3'h4;
  localparam logic [2:0]    IDX_SAT        = 3'h7;
  localparam logic [3:0]    UID_BYTES_LAST = 4'hF;
  localparam logic [7:0]    IDLE_BYTE      = 8'hFF;

  typedef enum logic [1:0] {
    ST_DESELECTED = 2'b00,
    ST_OPCODE     = 2'b01,
    ST_ACTIVE     = 2'b10,
    ST_STANDBY    = 2'b11
  } state_e;

  function automatic logic isKnown(input logic [7:0] op);
    case (op)
      OP_WR_ENABLE, OP_WR_DISABLE, OP_WR_EN_VOL, OP_RD_STATUS, OP_WR_STATUS,
      OP_READ, OP_FAST_READ, OP_DUAL_OUT, OP_DUAL_IO, OP_PAGE_ERASE,
      OP_SECT_ERASE, OP_HALF_ERASE, OP_BLK_ERASE, OP_CHIP_ERASE0,
      OP_CHIP_ERASE1, OP_PROGRAM, OP_POWER_DOWN, OP_WAKE_SIG, OP_MFR_ID,
      OP_DUAL_ID, OP_JEDEC_ID, OP_RST_ENABLE, OP_RST, OP_UNIQUE_ID: isKnown = 1'b1;
      default: isKnown = 1'b0;
    endcase
  endfunction

  // Commands that must end on a whole byte of clocks.
  function automatic logic isByteBound(input logic [7:0] op);
    case (op)
      OP_PROGRAM, OP_SECT_ERASE, OP_HALF_ERASE, OP_BLK_ERASE, OP_CHIP_ERASE0,
      OP_CHIP_ERASE1, OP_WR_STATUS, OP_WR_ENABLE, OP_WR_DISABLE,
      OP_POWER_DOWN, OP_PAGE_ERASE: isByteBound = 1'b1;
      default: isByteBound = 1'b0;
    endcase
  endfunction

  function automatic logic isDualIn(input logic [7:0] op);
    isDualIn = (op == OP_DUAL_IO) || (op == OP_DUAL_ID);
  endfunction

  function automatic logic isDualOut(input logic [7:0] op);
    isDualOut = (op == OP_DUAL_OUT) || (op == OP_DUAL_IO) || (op == OP_DUAL_ID);
  endfunction

  // Byte index at which data out begins; zero means no data out.
  function automatic logic [2:0] outStart(input logic [7:0] op);
    case (op)
      OP_RD_STATUS, OP_JEDEC_ID:                  outStart = 3'h1;
      OP_READ, OP_WAKE_SIG, OP_MFR_ID:            outStart = 3'h4;
      OP_FAST_READ, OP_DUAL_OUT, OP_DUAL_IO,
      OP_DUAL_ID, OP_UNIQUE_ID:                   outStart = 3'h5;
      default:                                    outStart = 3'h0;
    endcase
  endfunction

endpackage
`default_nettype wire

// *** verilog/byte_stream_if.sv ***
// Valid/ready byte stream carrier between the front end and its buffer.
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if #(parameter int WIDTH = 9) ();
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** verilog/two_entry_buffer.sv ***
// Two-entry valid/ready buffer in the received-byte path.
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
  parameter int WIDTH = 9
) (
  input wire logic     mclk,
  input wire logic     rst,
  byte_stream_if.snk   inPort,
  byte_stream_if.src   outPort
);

  if (WIDTH < 1)
  begin : gWidthCheck
    $error("two_entry_buffer needs WIDTH of at least 1");
  end

  logic [WIDTH-1:0] slot [2];
  logic             wrPtr;
  logic             rdPtr;
  logic [1:0]       count;
  logic             push;
  logic             pop;

  assign inPort.ready  = (count != 2'd2);
  assign outPort.valid = (count != 2'd0);
  assign outPort.data  = slot[rdPtr];
  assign push          = inPort.valid && inPort.ready;
  assign pop           = outPort.valid && outPort.ready;

  always_ff @(posedge mclk)
  begin
    if (push)
      slot[wrPtr] <= inPort.data;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'd0;
    end
    else
    begin
      if (push)
        wrPtr <= ~wrPtr;
      if (pop)
        rdPtr <= ~rdPtr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule
`default_nettype wire

// *** verilog/serial_flash_spi_front_end.sv ***
// Serial command front end of a small serial flash, sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_spi_front_end
  import serial_flash_pkg::*;
#(
  // Arbitrary identifier value; each part gets its own in production.
  parameter logic [127:0] UNIQUE_ID = 128'h1357_9BDF_0246_8ACE_FEDC_BA98_7654_3210
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic        dataLine0In,
  output logic             dataLine0Out,
  output logic             dataLine0Oe,
  input  wire logic        dataLine1In,
  output logic             dataLine1Out,
  output logic             dataLine1Oe,
  input  wire logic        opInProgress,
  input  wire logic [7:0]  statusBits,
  output logic             rxValid,
  input  wire logic        rxReady,
  output logic [8:0]       rxData,
  input  wire logic        txValid,
  input  wire logic [7:0]  txData,
  output logic             txReady,
  output logic             frameEnd,
  output logic             frameAligned,
  output logic             cmdAccepted,
  output logic             cmdReject,
  output logic             rxOverrun,
  output logic [23:0]      cmdAddr,
  output logic [5:0]       sectorIdx,
  output logic [9:0]       pageIdx,
  output logic [7:0]       pageOffset,
  output logic             inRange
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] sclkSync;
  logic [1:0] csSync;
  logic [1:0] d0Sync;
  logic [1:0] d1Sync;
  logic       sclkPrev;
  logic       csPrev;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sclkSync <= 2'b00;
      csSync   <= 2'b11;
      d0Sync   <= 2'b00;
      d1Sync   <= 2'b00;
      sclkPrev <= 1'b0;
      csPrev   <= 1'b1;
    end
    else
    begin
      sclkSync <= {sclkSync[0], sclk};
      csSync   <= {csSync[0], csN};
      d0Sync   <= {d0Sync[0], dataLine0In};
      d1Sync   <= {d1Sync[0], dataLine1In};
      sclkPrev <= sclkSync[1];
      csPrev   <= csSync[1];
    end
  end

  // Edges are found from the level, so mode 0 and mode 3 need no setting.
  logic sclkRise;
  logic sclkFall;
  logic csRise;
  logic deselected;
  assign sclkRise   = sclkSync[1] & ~sclkPrev;
  assign sclkFall   = ~sclkSync[1] & sclkPrev;
  assign csRise     = csSync[1] & ~csPrev;
  assign deselected = csSync[1];

  // ----------------------------------------------------------------
  // Frame state and input shifting
  // ----------------------------------------------------------------
  state_e     state;
  logic [7:0] opcode;
  logic [7:0] shiftIn;
  logic [2:0] bitCnt;
  logic [2:0] clkCnt;
  logic [2:0] byteIdx;
  logic       dualIn;
  logic       outPhase;
  logic       receiving;
  logic [7:0] next_shiftIn;
  logic [2:0] next_bitCnt;
  logic       byteDone;
  logic       rxPush;

  assign receiving = (state == ST_OPCODE) || (state == ST_ACTIVE);
  assign dualIn    = (state == ST_ACTIVE) && isDualIn(opcode)
                     && (byteIdx >= IDX_ADDR_FIRST) && (byteIdx <= IDX_MODE);
  assign next_shiftIn = dualIn ? {shiftIn[5:0], d1Sync[1], d0Sync[1]}
                               : {shiftIn[6:0], d0Sync[1]};
  assign next_bitCnt  = bitCnt + (dualIn ? 3'd2 : 3'd1);
  assign byteDone     = sclkRise && receiving && (next_bitCnt == 3'd0);
  assign rxPush       = byteDone && !outPhase;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      state <= ST_DESELECTED;
    else if (deselected)
      state <= ST_DESELECTED;
    else
    begin
      case (state)
        ST_DESELECTED: state <= ST_OPCODE;
        ST_OPCODE:
          if (byteDone)
            state <= isKnown(next_shiftIn) ? ST_ACTIVE : ST_STANDBY;
        ST_ACTIVE:     state <= ST_ACTIVE;
        ST_STANDBY:    state <= ST_STANDBY;
        default:       state <= ST_DESELECTED;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      shiftIn <= 8'h00;
      bitCnt  <= 3'd0;
      clkCnt  <= 3'd0;
      byteIdx <= 3'd0;
      opcode  <= 8'h00;
    end
    else if (deselected)
    begin
      bitCnt  <= 3'd0;
      clkCnt  <= 3'd0;
      byteIdx <= 3'd0;
    end
    else
    begin
      if (sclkRise)
        clkCnt <= clkCnt + 3'd1;
      if (sclkRise && receiving)
      begin
        shiftIn <= next_shiftIn;
        bitCnt  <= next_bitCnt;
      end
      if (byteDone && byteIdx != IDX_SAT)
        byteIdx <= byteIdx + 3'd1;
      if (byteDone && state == ST_OPCODE)
        opcode <= next_shiftIn;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // The first two address bytes collect here, so the address outputs load only once, together,
  // and never show a half-shifted address; pageOffset then steps on each program data byte.
  logic [15:0] addrShift;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      addrShift  <= 16'h0000;
      cmdAddr    <= ADDR_BOTTOM;
      sectorIdx  <= 6'd0;
      pageIdx    <= 10'd0;
      pageOffset <= 8'h00;
      // Address zero lies in the array, so the flag agrees with the reset address.
      inRange    <= 1'b1;
    end
    else if (rxPush && state == ST_ACTIVE)
    begin
      if (byteIdx >= IDX_ADDR_FIRST && byteIdx < IDX_ADDR_LAST)
        addrShift <= {addrShift[7:0], next_shiftIn};
      if (byteIdx == IDX_ADDR_LAST)
      begin
        cmdAddr    <= {addrShift, next_shiftIn};
        sectorIdx  <= addrShift[9:4];
        pageIdx    <= addrShift[9:0];
        pageOffset <= next_shiftIn;
        inRange    <= ({addrShift, next_shiftIn} <= ADDR_TOP);
      end
      else if (byteIdx > IDX_ADDR_LAST && opcode == OP_PROGRAM)
        pageOffset <= pageOffset + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Received byte buffer
  // ----------------------------------------------------------------
  // The link cannot be stalled, so a full buffer can only be reported.
  byte_stream_if #(.WIDTH(9)) rxIn ();
  byte_stream_if #(.WIDTH(9)) rxOut ();

  assign rxIn.valid   = rxPush;
  assign rxIn.data    = {state == ST_OPCODE, next_shiftIn};
  assign rxValid      = rxOut.valid;
  assign rxData       = rxOut.data;
  assign rxOut.ready  = rxReady;

  two_entry_buffer #(.WIDTH(9)) rxBuffer (
    .mclk    (mclk),
    .rst     (rst),
    .inPort  (rxIn),
    .outPort (rxOut)
  );

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rxOverrun <= 1'b0;
    else if (rxPush && !rxIn.ready)
      rxOverrun <= 1'b1;
    else if (state == ST_DESELECTED && !deselected)
      rxOverrun <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Output shifting
  // ----------------------------------------------------------------
  logic [7:0] txShift;
  logic [2:0] outCnt;
  logic [3:0] uidIdx;
  logic       dualOut;
  logic       localSource;
  logic [7:0] nextByte;
  logic       loadByte;

  assign dualOut     = isDualOut(opcode);
  assign outPhase    = (state == ST_ACTIVE) && (outStart(opcode) != 3'd0)
                       && (byteIdx >= outStart(opcode));
  assign localSource = (opcode == OP_RD_STATUS) || (opcode == OP_UNIQUE_ID);
  assign loadByte    = sclkFall && outPhase && (outCnt == 3'd0);
  assign txReady     = loadByte && !localSource;

  always_comb
  begin
    case (opcode)
      OP_RD_STATUS: nextByte = {statusBits[7:1], opInProgress};
      OP_UNIQUE_ID: nextByte = UNIQUE_ID[8'd127 - {uidIdx, 3'd0} -: 8];
      default:      nextByte = txValid ? txData : IDLE_BYTE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      txShift      <= 8'h00;
      outCnt       <= 3'd0;
      uidIdx       <= 4'd0;
      dataLine0Out <= 1'b0;
      dataLine1Out <= 1'b0;
    end
    else if (deselected)
    begin
      outCnt <= 3'd0;
      uidIdx <= 4'd0;
    end
    else if (sclkFall && outPhase)
    begin
      if (loadByte)
      begin
        dataLine1Out <= nextByte[7];
        dataLine0Out <= nextByte[6];
        txShift      <= dualOut ? {nextByte[5:0], 2'b00} : {nextByte[6:0], 1'b0};
        outCnt       <= dualOut ? 3'd6 : 3'd7;
        if (opcode == OP_UNIQUE_ID && uidIdx != UID_BYTES_LAST)
          uidIdx <= uidIdx + 4'd1;
      end
      else
      begin
        dataLine1Out <= txShift[7];
        dataLine0Out <= txShift[6];
        txShift      <= dualOut ? {txShift[5:0], 2'b00} : {txShift[6:0], 1'b0};
        outCnt       <= outCnt - (dualOut ? 3'd2 : 3'd1);
      end
    end
  end

  // Enables drop in the same cycle the state leaves active, a cycle after the synchronised chip select goes high.
  assign dataLine1Oe = outPhase;
  assign dataLine0Oe = outPhase && dualOut;

  // ----------------------------------------------------------------
  // Frame end checks
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      frameEnd     <= 1'b0;
      frameAligned <= 1'b0;
      cmdAccepted  <= 1'b0;
      cmdReject    <= 1'b0;
    end
    else
    begin
      frameEnd     <= csRise;
      frameAligned <= csRise && (clkCnt == 3'd0);
      cmdAccepted  <= csRise && (state == ST_ACTIVE) && isByteBound(opcode) && (clkCnt == 3'd0);
      cmdReject    <= csRise && (state == ST_ACTIVE) && isByteBound(opcode) && (clkCnt != 3'd0);
    end
  end

endmodule
`default_nettype wire

// *** tb/serial_flash_spi_front_end_assertions.sv ***
// Concurrent checks on the ports of the serial flash front end.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_spi_front_end_assertions (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        sclk,
  input wire logic        csN,
  input wire logic        dataLine0Oe,
  input wire logic        dataLine1Oe,
  input wire logic        dataLine1Out,
  input wire logic        txReady,
  input wire logic        frameEnd,
  input wire logic        frameAligned,
  input wire logic        cmdAccepted,
  input wire logic        cmdReject,
  input wire logic [23:0] cmdAddr,
  input wire logic [5:0]  sectorIdx,
  input wire logic [9:0]  pageIdx,
  input wire logic        inRange
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  csHighRelease_a: assert property (csN [*4] |-> !dataLine0Oe && !dataLine1Oe)
    else $error("data line driven while deselected");
  acceptAligned_a: assert property (cmdAccepted |-> frameEnd && frameAligned)
    else $error("command accepted off a byte boundary");
  rejectUnaligned_a: assert property (cmdReject |-> frameEnd && !frameAligned)
    else $error("command rejected on a byte boundary");
  frameEndCause_a: assert property (frameEnd |-> csN && $past(csN, 2))
    else $error("frame end without chip select rise");
  sectorPage_a: assert property (sectorIdx == cmdAddr[17:12] && pageIdx == cmdAddr[17:8])
    else $error("sector or page index does not match address");
  rangeFlag_a: assert property (inRange == (cmdAddr <= 24'h03_FFFF))
    else $error("range flag does not match address");
  dualPair_a: assert property (dataLine0Oe |-> dataLine1Oe)
    else $error("line zero driven without line one");
  launchOnFall_a: assert property (dataLine1Oe && $changed(dataLine1Out) |-> !$past(sclk, 2))
    else $error("output bit changed outside a clock fall");
  txOnFall_a: assert property (txReady |-> !$past(sclk, 2))
    else $error("byte fetched outside a clock fall");

  acceptSeen_c: cover property (cmdAccepted);
  rejectSeen_c: cover property (cmdReject);
  dualSeen_c: cover property (dataLine0Oe && dataLine1Oe);
endmodule

bind serial_flash_spi_front_end serial_flash_spi_front_end_assertions u_chk (
  .mclk(mclk), .rst(rst), .sclk(sclk), .csN(csN), .dataLine0Oe(dataLine0Oe), .dataLine1Oe(dataLine1Oe),
  .dataLine1Out(dataLine1Out), .txReady(txReady), .frameEnd(frameEnd), .frameAligned(frameAligned),
  .cmdAccepted(cmdAccepted), .cmdReject(cmdReject), .cmdAddr(cmdAddr), .sectorIdx(sectorIdx),
  .pageIdx(pageIdx), .inRange(inRange));
`default_nettype wire

// *** tb/spi_host_model.sv ***
// Behavioural serial host that frames commands and resolves both data lines.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input  wire logic mclk,
  input  wire logic devOut0,
  input  wire logic devOe0,
  input  wire logic devOut1,
  input  wire logic devOe1,
  output var logic  sclk,
  output var logic  csN,
  output wire logic line0,
  output wire logic line1
);
  logic hostOe;
  logic hostBit;
  logic hostBit1;
  logic floatBit;
  // Set by the bench for commands whose address and mode bytes use both lines.
  logic dualAddr;

  initial
  begin
    sclk = 1'b0;
    csN = 1'b1;
    hostOe = 1'b0;
    hostBit = 1'b0;
    hostBit1 = 1'b0;
    floatBit = 1'b0;
    dualAddr = 1'b0;
  end

  // An undriven line toggles so that a stale level can never pass for data.
  always @(posedge mclk) floatBit <= !floatBit;
  assign line0 = devOe0 ? devOut0 : (hostOe ? hostBit : floatBit);
  assign line1 = devOe1 ? devOut1 : ((hostOe && dualAddr) ? hostBit1 : floatBit);

  task automatic frame(input bit idleHigh, input logic [63:0] tx, input int nOut, input int nIn,
                       input bit dual, output logic [7:0] got);
    got = 8'h00;
    @(posedge mclk);
    sclk <= idleHigh;
    @(posedge mclk);
    csN <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < nOut + nIn; i++)
    begin
      sclk <= 1'b0;
      hostOe <= (i < nOut);
      if (dualAddr && i >= 8)
      begin
        hostBit1 <= (i < nOut) ? tx[63 - (2 * i - 8)] : 1'b0;
        hostBit  <= (i < nOut) ? tx[62 - (2 * i - 8)] : 1'b0;
      end
      else
        hostBit <= (i < nOut) ? tx[63 - i] : 1'b0;
      repeat (4) @(posedge mclk);
      sclk <= 1'b1;
      // Sampling two cycles late leaves room for the device's synchroniser delay.
      repeat (2) @(posedge mclk);
      if (i >= nOut)
        got = dual ? {got[5:0], line1, line0} : {got[6:0], line1};
      repeat (2) @(posedge mclk);
    end
    sclk <= idleHigh;
    @(posedge mclk);
    csN <= 1'b1;
    hostOe <= 1'b0;
    repeat (12) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the serial flash front end.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import serial_flash_pkg::*;
;
  // Arbitrary identifier value.
  localparam logic [127:0] UID = 128'hC3A5_0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2;
  typedef struct {logic [7:0] op; logic [23:0] addr; int nClk; bit hi; int acc; int rej; int n;} row_s;

  logic        mclk, rst, sclk, csN, line0, line1, out0, oe0, out1, oe1;
  logic        opInProgress, rxValid, rxReady, txValid, txReady, frameEnd, frameAligned;
  logic        cmdAccepted, cmdReject, rxOverrun, inRange;
  logic [7:0]  statusBits, txData, pageOffset, got;
  logic [8:0]  rxData;
  logic [23:0] cmdAddr;
  logic [5:0]  sectorIdx;
  logic [9:0]  pageIdx;
  logic [8:0]  rxQ[$];
  int          miscompares, checksDone, accCnt, rejCnt, oeCnt, a0, j0, e0;
  row_s        rows[7] = '{
    '{OP_WR_ENABLE, 24'h00_0000, 8, 0, 1, 0, 1}, '{OP_WR_ENABLE, 24'h00_0000, 9, 1, 0, 1, 1},
    '{OP_SECT_ERASE, 24'h03_F123, 32, 0, 1, 0, 4}, '{OP_HALF_ERASE, 24'h01_0000, 31, 1, 0, 1, 3},
    '{OP_READ, 24'h04_0000, 32, 0, 0, 0, 4}, '{8'hFF, 24'h00_0000, 32, 0, 0, 0, 1},
    '{OP_PROGRAM, 24'h02_3456, 40, 1, 1, 0, 5}};

  serial_flash_spi_front_end #(.UNIQUE_ID(UID)) u_serial_flash_spi_front_end (
    .mclk(mclk), .rst(rst), .sclk(sclk), .csN(csN), .dataLine0In(line0), .dataLine0Out(out0),
    .dataLine0Oe(oe0), .dataLine1In(line1), .dataLine1Out(out1), .dataLine1Oe(oe1),
    .opInProgress(opInProgress), .statusBits(statusBits), .rxValid(rxValid), .rxReady(rxReady),
    .rxData(rxData), .txValid(txValid), .txData(txData), .txReady(txReady), .frameEnd(frameEnd),
    .frameAligned(frameAligned), .cmdAccepted(cmdAccepted), .cmdReject(cmdReject), .rxOverrun(rxOverrun),
    .cmdAddr(cmdAddr), .sectorIdx(sectorIdx), .pageIdx(pageIdx), .pageOffset(pageOffset), .inRange(inRange));

  spi_host_model u_host (.mclk(mclk), .devOut0(out0), .devOe0(oe0), .devOut1(out1), .devOe1(oe1),
    .sclk(sclk), .csN(csN), .line0(line0), .line1(line1));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    if (cmdAccepted === 1'b1) accCnt++;
    if (cmdReject === 1'b1) rejCnt++;
    if (oe1 === 1'b1) oeCnt++;
    if (rxValid === 1'b1 && rxReady === 1'b1) rxQ.push_back(rxData);
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checksDone++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask

  task automatic completeRun();
    if (miscompares == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge mclk);
    miscompares++;
    completeRun();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    rxReady = 1'b1;
    txValid = 1'b1;
    txData = 8'h00;
    statusBits = 8'h00;
    opInProgress = 1'b0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    foreach (rows[r])
    begin
      a0 = accCnt;
      j0 = rejCnt;
      e0 = oeCnt;
      rxQ.delete();
      u_host.frame(rows[r].hi, {rows[r].op, rows[r].addr, 32'h0000_0000}, rows[r].nClk, 0, 1'b0, got);
      check("opcode byte", {23'h0, 1'b1, rows[r].op}, (rxQ.size() > 0) ? {23'h0, rxQ[0]} : 32'h0);
      check("byte count", rows[r].n, rxQ.size());
      check("accepted", rows[r].acc, accCnt - a0);
      check("rejected", rows[r].rej, rejCnt - j0);
      if (rows[r].op == 8'hFF) check("standby drive", 0, oeCnt - e0);
      if (rows[r].n >= 4)
      begin
        check("address", {8'h0, rows[r].addr}, {8'h0, cmdAddr});
        check("sector", {26'h0, rows[r].addr[17:12]}, {26'h0, sectorIdx});
      end
      if (rows[r].op == OP_PROGRAM) check("page offset", rows[r].addr[7:0] + 8'h01, {24'h0, pageOffset});
    end
    statusBits <= 8'hA4;
    opInProgress <= 1'b1;
    u_host.frame(1'b0, {OP_RD_STATUS, 56'h0}, 8, 8, 1'b0, got);
    check("status busy", 32'h0000_00A5, {24'h0, got});
    opInProgress <= 1'b0;
    u_host.frame(1'b1, {OP_RD_STATUS, 56'h0}, 8, 8, 1'b0, got);
    check("status idle", 32'h0000_00A4, {24'h0, got});
    txData <= 8'h96;
    u_host.frame(1'b0, {OP_DUAL_OUT, 24'h00_0100, 32'h0}, 40, 4, 1'b1, got);
    check("dual read", 32'h0000_0096, {24'h0, got});
    // Dual io read: address and mode byte come in two bits per clock.
    u_host.dualAddr <= 1'b1;
    txData <= 8'h5A;
    u_host.frame(1'b1, {OP_DUAL_IO, 24'h01_2345, 8'h00, 24'h0}, 24, 4, 1'b1, got);
    u_host.dualAddr <= 1'b0;
    check("dual io addr", 32'h0001_2345, {8'h0, cmdAddr});
    check("dual io data", 32'h0000_005A, {24'h0, got});
    u_host.frame(1'b1, {OP_UNIQUE_ID, 56'h0}, 40, 8, 1'b0, got);
    check("unique id", {24'h0, UID[127:120]}, {24'h0, got});
    // The receiver stalls across a two-byte frame; both bytes must survive.
    rxReady <= 1'b0;
    rxQ.delete();
    u_host.frame(1'b0, {OP_WR_EN_VOL, 8'h3C, 48'h0}, 16, 0, 1'b0, got);
    check("stall overrun", 0, {31'h0, rxOverrun});
    rxReady <= 1'b1;
    repeat (6) @(posedge mclk);
    check("stall count", 2, rxQ.size());
    check("stall data", 32'h0000_003C, (rxQ.size() > 1) ? {23'h0, rxQ[1]} : 32'h0);
    // A third byte against a full buffer must raise the overrun flag.
    rxReady <= 1'b0;
    u_host.frame(1'b0, {OP_READ, 56'h0}, 24, 0, 1'b0, got);
    check("overrun flag", 1, {31'h0, rxOverrun});
    rxReady <= 1'b1;
    // A second reset in mid-run must leave the link usable.
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    check("reset release", 0, {31'h0, oe1});
    u_host.frame(1'b0, {OP_RD_STATUS, 56'h0}, 8, 8, 1'b0, got);
    check("status after reset", 32'h0000_00A4, {24'h0, got});
    completeRun();
  end
endmodule
`default_nettype wire
